// file: rtl/bfs_pkg.sv
package bfs_pkg;

  // Clock and timing
  localparam int CLK_HZ        = 25_000_000;
  localparam int PG_RISE_US    = 1000;
  localparam int PG_FALL_NS    = 2000;
  localparam int UV_DELAY_US   = 1000;
  localparam int PG_RISE_CYC   = (CLK_HZ / 1_000_000) * PG_RISE_US;
  localparam int PG_FALL_CYC   = ((CLK_HZ / 1_000_000) * PG_FALL_NS) / 1000;
  localparam int UV_DELAY_CYC  = (CLK_HZ / 1_000_000) * UV_DELAY_US;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0] ADDR_ON_TIME  = 8'h10;
  localparam logic [7:0] ADDR_MIN_ON   = 8'h14;
  localparam logic [7:0] ADDR_ZC_DLY   = 8'h18;

  // Reset values
  localparam logic       CTRL_RST      = 1'b1;
  localparam logic [7:0] ON_TIME_RST   = 8'h10;
  localparam logic [7:0] MIN_ON_RST    = 8'h04;
  localparam logic [3:0] ZC_DLY_RST    = 4'h4;
  localparam logic [6:0] IRQ_MASK_RST  = 7'h00;

  // Event bits in IRQ_STAT / IRQ_MASK
  localparam int EV_PG_RISE  = 0;
  localparam int EV_PG_FALL  = 1;
  localparam int EV_UV_FAULT = 2;
  localparam int EV_OV_FAULT = 3;
  localparam int EV_BAND     = 4;
  localparam int EV_LOCKOUT  = 5;
  localparam int EV_THERMAL  = 6;
  localparam int EV_N        = 7;

  // Synchronised comparator flag positions
  localparam int SY_SS_DONE  = 0;
  localparam int SY_IN_WIN   = 1;
  localparam int SY_OUT_WIN  = 2;
  localparam int SY_UV       = 3;
  localparam int SY_OV       = 4;
  localparam int SY_BAND     = 5;
  localparam int SY_VALLEY   = 6;
  localparam int SY_NEGLIM   = 7;
  localparam int SY_ZC       = 8;
  localparam int SY_SUP_LOW  = 9;
  localparam int SY_SUP_OK   = 10;
  localparam int SY_HOT      = 11;
  localparam int SY_COOL     = 12;
  localparam int SY_EN       = 13;
  localparam int SY_PWM      = 14;
  localparam int SY_ZC_LATE  = 15;
  localparam int SY_ZC_EARLY = 16;
  localparam int SY_BIAS_RST = 17;
  localparam int SY_MODE_PG  = 18;
  localparam int SY_N        = 19;

  typedef enum logic [2:0] {
    BFS_SW_OFF,
    BFS_SW_HIGH,
    BFS_SW_LOW,
    BFS_SW_OV_LOW,
    BFS_SW_OV_HIGH
  } bfs_sw_state_t;

endpackage : bfs_pkg

// file: rtl/bfs_buck_fault_supervisor.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Power-good held low until soft-start done
// - In +-8% window for 1 ms raises power-good
// - Outside +-16% for 2 us drops power-good
// - Valley overcurrent holds off, no new pulse
// - Below 68% for 1 ms latches both off
// - Undervoltage check only after soft-start
// - Above 120%: high off, low on
// - Negative limit: low off, min on-time high
// - Below UV 1 ms ends cycling: low latched on
// - Faults clear only by bias cycle or enable
// - 8% band: forced low-side discharge, no latch
// - Supply lockout stops switching, auto resume
// - Thermal shutdown with hysteresis, no latch
// - Skip mode: low off at zero current
// - Discontinuous on-time equals continuous on-time
// - Power-good tie keeps continuous conduction
// - Forced continuous only after power-good high
// - Adaptive zero-cross delay cancels offset, delay
module bfs_buck_fault_supervisor #(
  parameter logic [15:0] PG_RISE_CYC  = 16'(bfs_pkg::PG_RISE_CYC),
  parameter logic [15:0] UV_DELAY_CYC = 16'(bfs_pkg::UV_DELAY_CYC)
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        soft_start_done,
  input  wire logic        fb_in_window,
  input  wire logic        fb_out_window,
  input  wire logic        fb_below_uv,
  input  wire logic        fb_above_ov,
  input  wire logic        fb_above_band,
  input  wire logic        valley_over_trip,
  input  wire logic        neg_current_limit,
  input  wire logic        zero_current,
  input  wire logic        supply_below_off,
  input  wire logic        supply_above_on,
  input  wire logic        temp_over,
  input  wire logic        temp_recovered,
  input  wire logic        enable_pin,
  input  wire logic        pwm_request,
  input  wire logic        zc_too_late,
  input  wire logic        zc_too_early,
  input  wire logic        bias_reset,
  input  wire logic        mode_tied_pg,
  output logic             high_side_on,
  output logic             low_side_on,
  output logic             output_ok_flag,
  output logic             irq
);

  logic [bfs_pkg::SY_N-1:0] sync1_q;
  logic [bfs_pkg::SY_N-1:0] sync2_q;
  logic [bfs_pkg::SY_N-1:0] raw;

  logic                     ctrl_en_q;
  logic [bfs_pkg::EV_N-1:0] irq_stat_q;
  logic [bfs_pkg::EV_N-1:0] irq_mask_q;
  logic [7:0]               on_time_q;
  logic [7:0]               min_on_q;
  logic [3:0]               zc_dly_q;

  logic        pg_q;
  logic [15:0] pg_cnt_q;
  logic [15:0] uv_cnt_q;
  logic        undervoltage_fault;
  logic        overvoltage_fault;
  logic        ov_final_q;
  logic        supply_low_lockout;
  logic        thermal_off_q;
  logic        band_q;
  logic        en_prev_q;

  bfs_pkg::bfs_sw_state_t sw_q;
  logic [7:0]  tmr_q;
  logic [3:0]  zc_cnt_q;
  logic        zc_arm_q;
  logic        ls_cut_q;

  logic        ss_done;
  logic        running;
  logic        halted;
  logic        forced_continuous_mode;
  logic        fault_clear;
  logic        apb_access;
  logic        apb_wr;
  logic        apb_rd;
  logic [bfs_pkg::EV_N-1:0] ev;
  logic [bfs_pkg::EV_N-1:0] ev_w1c;
  logic [31:0] rd_val;
  logic        addr_ok;

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == bfs_pkg::ADDR_CTRL) || (a == bfs_pkg::ADDR_STATUS) ||
                  (a == bfs_pkg::ADDR_IRQ_STAT) || (a == bfs_pkg::ADDR_IRQ_MASK) ||
                  (a == bfs_pkg::ADDR_ON_TIME) || (a == bfs_pkg::ADDR_MIN_ON) ||
                  (a == bfs_pkg::ADDR_ZC_DLY);
  endfunction : addr_mapped

  // Comparators are asynchronous to pclk; only the second stage is used
  assign raw = {mode_tied_pg, bias_reset, zc_too_early, zc_too_late, pwm_request,
                enable_pin, temp_recovered, temp_over, supply_above_on, supply_below_off,
                zero_current, neg_current_limit, valley_over_trip, fb_above_band,
                fb_above_ov, fb_below_uv, fb_out_window, fb_in_window, soft_start_done};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
    end
  end

  assign ss_done     = sync2_q[bfs_pkg::SY_SS_DONE];
  assign fault_clear = sync2_q[bfs_pkg::SY_BIAS_RST] ||
                       (sync2_q[bfs_pkg::SY_EN] && !en_prev_q);
  assign halted      = supply_low_lockout || thermal_off_q;
  assign running     = ctrl_en_q && sync2_q[bfs_pkg::SY_EN] && !halted;
  // Power-good tie only takes effect once power-good is high
  assign forced_continuous_mode = sync2_q[bfs_pkg::SY_MODE_PG] && pg_q;

  // Lockout and thermal both use separate off/on comparators for hysteresis
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_low_lockout <= 1'b1;
      thermal_off_q      <= 1'b0;
      en_prev_q          <= 1'b0;
    end else begin
      en_prev_q <= sync2_q[bfs_pkg::SY_EN];
      if (sync2_q[bfs_pkg::SY_SUP_LOW]) begin
        supply_low_lockout <= 1'b1;
      end else if (sync2_q[bfs_pkg::SY_SUP_OK]) begin
        supply_low_lockout <= 1'b0;
      end
      if (sync2_q[bfs_pkg::SY_HOT]) begin
        thermal_off_q <= 1'b1;
      end else if (sync2_q[bfs_pkg::SY_COOL]) begin
        thermal_off_q <= 1'b0;
      end
    end
  end

  // Power-good qualification; counter restarts whenever the condition breaks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_q     <= 1'b0;
      pg_cnt_q <= 16'h0000;
    end else if (!ss_done || !running || undervoltage_fault || overvoltage_fault) begin
      pg_q     <= 1'b0;
      pg_cnt_q <= 16'h0000;
    end else if (!pg_q) begin
      if (!sync2_q[bfs_pkg::SY_IN_WIN]) begin
        pg_cnt_q <= 16'h0000;
      end else if (pg_cnt_q == PG_RISE_CYC - 16'h0001) begin
        pg_q     <= 1'b1;
        pg_cnt_q <= 16'h0000;
      end else begin
        pg_cnt_q <= pg_cnt_q + 16'h0001;
      end
    end else begin
      if (!sync2_q[bfs_pkg::SY_OUT_WIN]) begin
        pg_cnt_q <= 16'h0000;
      end else if (pg_cnt_q == 16'(bfs_pkg::PG_FALL_CYC) - 16'h0001) begin
        pg_q     <= 1'b0;
        pg_cnt_q <= 16'h0000;
      end else begin
        pg_cnt_q <= pg_cnt_q + 16'h0001;
      end
    end
  end

  // Undervoltage delay counter, shared by the UV latch and the OV exit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_cnt_q           <= 16'h0000;
      undervoltage_fault <= 1'b0;
      overvoltage_fault  <= 1'b0;
      ov_final_q         <= 1'b0;
    end else if (fault_clear) begin
      uv_cnt_q           <= 16'h0000;
      undervoltage_fault <= 1'b0;
      overvoltage_fault  <= 1'b0;
      ov_final_q         <= 1'b0;
    end else begin
      if (!sync2_q[bfs_pkg::SY_UV] || (!ss_done && !overvoltage_fault) ||
          undervoltage_fault || ov_final_q) begin
        uv_cnt_q <= 16'h0000;
      end else if (uv_cnt_q == UV_DELAY_CYC - 16'h0001) begin
        uv_cnt_q <= 16'h0000;
        if (overvoltage_fault) begin
          ov_final_q <= 1'b1;
        end else begin
          undervoltage_fault <= 1'b1;
        end
      end else begin
        uv_cnt_q <= uv_cnt_q + 16'h0001;
      end
      if (sync2_q[bfs_pkg::SY_OV] && !undervoltage_fault && running) begin
        overvoltage_fault <= 1'b1;
      end
    end
  end

  // Soft overvoltage band is not a latch: it follows the comparator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      band_q <= 1'b0;
    end else begin
      band_q <= sync2_q[bfs_pkg::SY_BAND] && running;
    end
  end

  // Adaptive zero-cross delay: late detection shortens it, early lengthens it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zc_dly_q <= bfs_pkg::ZC_DLY_RST;
    end else if (sync2_q[bfs_pkg::SY_ZC_LATE] && zc_dly_q != 4'h0) begin
      zc_dly_q <= zc_dly_q - 4'h1;
    end else if (sync2_q[bfs_pkg::SY_ZC_EARLY] && !sync2_q[bfs_pkg::SY_ZC_LATE] &&
                 zc_dly_q != 4'hF) begin
      zc_dly_q <= zc_dly_q + 4'h1;
    end
  end

  // Switching sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_q     <= bfs_pkg::BFS_SW_OFF;
      tmr_q    <= 8'h00;
      zc_cnt_q <= 4'h0;
      zc_arm_q <= 1'b0;
      ls_cut_q <= 1'b0;
    end else if (halted || !running || undervoltage_fault || ov_final_q) begin
      sw_q     <= bfs_pkg::BFS_SW_OFF;
      zc_arm_q <= 1'b0;
      ls_cut_q <= 1'b0;
    end else if (overvoltage_fault && sw_q != bfs_pkg::BFS_SW_OV_LOW &&
                 sw_q != bfs_pkg::BFS_SW_OV_HIGH) begin
      sw_q <= bfs_pkg::BFS_SW_OV_LOW;
    end else begin
      case (sw_q)
        bfs_pkg::BFS_SW_OFF: begin
          if (sync2_q[bfs_pkg::SY_PWM] && !sync2_q[bfs_pkg::SY_VALLEY]) begin
            sw_q  <= bfs_pkg::BFS_SW_HIGH;
            tmr_q <= on_time_q;
          end
        end
        bfs_pkg::BFS_SW_HIGH: begin
          // Same on-time whether conduction is continuous or not
          if (tmr_q <= 8'h01) begin
            sw_q     <= bfs_pkg::BFS_SW_LOW;
            zc_arm_q <= 1'b0;
            ls_cut_q <= 1'b0;
          end else begin
            tmr_q <= tmr_q - 8'h01;
          end
        end
        bfs_pkg::BFS_SW_LOW: begin
          if (sync2_q[bfs_pkg::SY_PWM] && !sync2_q[bfs_pkg::SY_VALLEY]) begin
            sw_q  <= bfs_pkg::BFS_SW_HIGH;
            tmr_q <= on_time_q;
          end else if (band_q) begin
            // Discharge past zero current, bounded by the negative limit
            ls_cut_q <= sync2_q[bfs_pkg::SY_NEGLIM];
            zc_arm_q <= 1'b0;
          end else if (!forced_continuous_mode) begin
            if (zc_arm_q) begin
              if (zc_cnt_q == 4'h0) begin
                ls_cut_q <= 1'b1;
                zc_arm_q <= 1'b0;
              end else begin
                zc_cnt_q <= zc_cnt_q - 4'h1;
              end
            end else if (sync2_q[bfs_pkg::SY_ZC] && !ls_cut_q) begin
              zc_arm_q <= 1'b1;
              zc_cnt_q <= zc_dly_q;
            end
          end else begin
            ls_cut_q <= 1'b0;
            zc_arm_q <= 1'b0;
          end
        end
        bfs_pkg::BFS_SW_OV_LOW: begin
          if (sync2_q[bfs_pkg::SY_NEGLIM]) begin
            sw_q  <= bfs_pkg::BFS_SW_OV_HIGH;
            tmr_q <= min_on_q;
          end
        end
        bfs_pkg::BFS_SW_OV_HIGH: begin
          if (tmr_q <= 8'h01) begin
            sw_q <= bfs_pkg::BFS_SW_OV_LOW;
          end else begin
            tmr_q <= tmr_q - 8'h01;
          end
        end
        default: begin
          sw_q <= bfs_pkg::BFS_SW_OFF;
        end
      endcase
    end
  end

  // Driver outputs registered; never both on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_side_on <= 1'b0;
      low_side_on  <= 1'b0;
    end else if (halted || undervoltage_fault) begin
      high_side_on <= 1'b0;
      low_side_on  <= 1'b0;
    end else if (ov_final_q) begin
      high_side_on <= 1'b0;
      low_side_on  <= 1'b1;
    end else begin
      high_side_on <= (sw_q == bfs_pkg::BFS_SW_HIGH) || (sw_q == bfs_pkg::BFS_SW_OV_HIGH);
      low_side_on  <= ((sw_q == bfs_pkg::BFS_SW_LOW) && !ls_cut_q) ||
                      (sw_q == bfs_pkg::BFS_SW_OV_LOW);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_ok_flag <= 1'b0;
    end else begin
      output_ok_flag <= pg_q;
    end
  end

  // APB slave: one wait state, pready and prdata registered
  assign apb_access = psel && penable && !pready;
  assign apb_wr     = apb_access && pwrite;
  assign apb_rd     = apb_access && !pwrite;
  assign addr_ok    = addr_mapped(paddr);

  always_comb begin
    rd_val = 32'h0000_0000;
    case (paddr)
      bfs_pkg::ADDR_CTRL:     rd_val[0] = ctrl_en_q;
      bfs_pkg::ADDR_STATUS:   rd_val[9:0] = {forced_continuous_mode, ov_final_q, band_q,
                                             thermal_off_q, supply_low_lockout,
                                             overvoltage_fault, undervoltage_fault,
                                             ss_done, pg_q, running};
      bfs_pkg::ADDR_IRQ_STAT: rd_val[bfs_pkg::EV_N-1:0] = irq_stat_q;
      bfs_pkg::ADDR_IRQ_MASK: rd_val[bfs_pkg::EV_N-1:0] = irq_mask_q;
      bfs_pkg::ADDR_ON_TIME:  rd_val[7:0] = on_time_q;
      bfs_pkg::ADDR_MIN_ON:   rd_val[7:0] = min_on_q;
      bfs_pkg::ADDR_ZC_DLY:   rd_val[3:0] = zc_dly_q;
      default:                rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_access;
      pslverr <= apb_access && !addr_ok;
      prdata  <= apb_rd ? rd_val : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_q  <= bfs_pkg::CTRL_RST;
      irq_mask_q <= bfs_pkg::IRQ_MASK_RST;
      on_time_q  <= bfs_pkg::ON_TIME_RST;
      min_on_q   <= bfs_pkg::MIN_ON_RST;
    end else if (apb_wr) begin
      case (paddr)
        bfs_pkg::ADDR_CTRL:     ctrl_en_q  <= pwdata[0];
        bfs_pkg::ADDR_IRQ_MASK: irq_mask_q <= pwdata[bfs_pkg::EV_N-1:0];
        bfs_pkg::ADDR_ON_TIME:  on_time_q  <= pwdata[7:0];
        bfs_pkg::ADDR_MIN_ON:   min_on_q   <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Events: rising edges of the state they report
  assign ev[bfs_pkg::EV_PG_RISE]  = pg_q && !output_ok_flag;
  assign ev[bfs_pkg::EV_PG_FALL]  = !pg_q && output_ok_flag;
  assign ev[bfs_pkg::EV_UV_FAULT] = sync2_q[bfs_pkg::SY_UV] && (uv_cnt_q == UV_DELAY_CYC - 16'h0001) &&
                                    !overvoltage_fault && ss_done && !fault_clear;
  assign ev[bfs_pkg::EV_OV_FAULT] = sync2_q[bfs_pkg::SY_OV] && !overvoltage_fault &&
                                    !undervoltage_fault && running && !fault_clear;
  assign ev[bfs_pkg::EV_BAND]     = sync2_q[bfs_pkg::SY_BAND] && running && !band_q;
  assign ev[bfs_pkg::EV_LOCKOUT]  = sync2_q[bfs_pkg::SY_SUP_LOW] && !supply_low_lockout;
  assign ev[bfs_pkg::EV_THERMAL]  = sync2_q[bfs_pkg::SY_HOT] && !thermal_off_q;
  assign ev_w1c = (apb_wr && paddr == bfs_pkg::ADDR_IRQ_STAT) ? pwdata[bfs_pkg::EV_N-1:0] : '0;

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
      irq        <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~ev_w1c) | ev;
      irq        <= |(((irq_stat_q & ~ev_w1c) | ev) & irq_mask_q);
    end
  end

endmodule : bfs_buck_fault_supervisor

// file: verification/bfs_buck_fault_supervisor_checker.sv
`timescale 1ns/1ns
module bfs_buck_fault_supervisor_checker #(
  parameter logic [15:0] PG_RISE_CYC  = 16'h0020,
  parameter logic [15:0] UV_DELAY_CYC = 16'h0020
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic soft_start_done,
  input wire logic fb_in_window,
  input wire logic fb_out_window,
  input wire logic fb_below_uv,
  input wire logic fb_above_ov,
  input wire logic valley_over_trip,
  input wire logic neg_current_limit,
  input wire logic supply_below_off,
  input wire logic temp_over,
  input wire logic enable_pin,
  input wire logic bias_reset,
  input wire logic high_side_on,
  input wire logic low_side_on,
  input wire logic output_ok_flag
);
  logic [15:0] in_cnt_q, out_cnt_q, uv_cnt_q;
  logic        ov_seen_q, en_q, clr;

  assign clr = bias_reset || (enable_pin && !en_q);

  // Run lengths on the raw pins; slack below covers the design's sync and output stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_cnt_q  <= 16'h0000;
      out_cnt_q <= 16'h0000;
      uv_cnt_q  <= 16'h0000;
      ov_seen_q <= 1'b0;
      en_q      <= 1'b0;
    end else begin
      in_cnt_q  <= fb_in_window ? in_cnt_q + 16'(in_cnt_q != 16'hFFFF) : 16'h0000;
      out_cnt_q <= fb_out_window ? out_cnt_q + 16'(out_cnt_q != 16'hFFFF) : 16'h0000;
      uv_cnt_q  <= (fb_below_uv && soft_start_done && !clr) ? uv_cnt_q + 16'(uv_cnt_q != 16'hFFFF) : 16'h0000;
      ov_seen_q <= fb_above_ov || (ov_seen_q && !clr);
      en_q      <= enable_pin;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_PG_NEEDS_SS: assert property (
    !soft_start_done [*5] |-> !output_ok_flag) else $error("power good high without soft start");
  AST_PG_RISE_DELAY: assert property (
    $rose(output_ok_flag) |-> $past(in_cnt_q, 4) >= PG_RISE_CYC - 16'h0002) else $error("power good rose early");
  AST_PG_FALL_DELAY: assert property (
    out_cnt_q >= 16'h003A |-> !output_ok_flag) else $error("power good not dropped");
  AST_VALLEY_HOLD_OFF: assert property (
    valley_over_trip [*5] |-> !$rose(high_side_on)) else $error("high side pulse during overcurrent");
  AST_UV_LATCH_OFF: assert property (
    uv_cnt_q >= UV_DELAY_CYC + 16'h0008 && !ov_seen_q |-> !high_side_on && !low_side_on)
    else $error("undervoltage did not latch drivers off");
  AST_OV_HIGH_OFF: assert property (
    (fb_above_ov && !neg_current_limit) [*8] |=> !high_side_on) else $error("high side on during overvoltage");
  AST_LOCKOUT_OFF: assert property (
    supply_below_off [*5] |-> !high_side_on && !low_side_on) else $error("switching during supply lockout");
  AST_THERMAL_OFF: assert property (
    temp_over [*5] |-> !high_side_on && !low_side_on) else $error("switching while overheated");
  AST_APB_ANSWER: assert property (
    psel && penable && !pready |=> pready) else $error("bus access not answered");
endmodule : bfs_buck_fault_supervisor_checker

bind bfs_buck_fault_supervisor bfs_buck_fault_supervisor_checker #(
  .PG_RISE_CYC (PG_RISE_CYC),
  .UV_DELAY_CYC(UV_DELAY_CYC)
) i_bfs_buck_fault_supervisor_checker (.*);

// file: verification/bfs_power_stage.sv
`timescale 1ns/1ns
module bfs_power_stage #(
  parameter int TRIP = 100,
  parameter int NEG  = 8
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic high_side_on,
  input  wire logic low_side_on,
  input  wire logic force_trip,
  output logic      valley_over_trip,
  output logic      neg_current_limit,
  output logic      zero_current
);
  int cur_q;

  // Coarse inductor: steep rise through the high side, slow ramp otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_q <= 0;
    end else if (high_side_on) begin
      cur_q <= cur_q + 4;
    end else if (low_side_on) begin
      cur_q <= cur_q - int'(cur_q > -100);
    end else begin
      cur_q <= cur_q - int'(cur_q > 0) + int'(cur_q < 0);
    end
  end

  assign valley_over_trip  = force_trip || (!high_side_on && cur_q > TRIP);
  assign neg_current_limit = cur_q < -NEG;
  assign zero_current      = low_side_on && cur_q <= 0;
endmodule : bfs_power_stage

// file: verification/test_buck_fault_supervisor.sv
`timescale 1ns/1ns
module test_buck_fault_supervisor;
  localparam logic [15:0] PG_N = 16'h001E;
  localparam logic [15:0] UV_N = 16'h0028;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, force_trip;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        soft_start_done, fb_in_window, fb_out_window, fb_below_uv, fb_above_ov, fb_above_band;
  logic        valley_over_trip, neg_current_limit, zero_current, supply_below_off, supply_above_on;
  logic        temp_over, temp_recovered, enable_pin, pwm_request, zc_too_late, zc_too_early;
  logic        bias_reset, mode_tied_pg, high_side_on, low_side_on, output_ok_flag;
  logic [32:0] exp_q[$];
  logic [7:0]  ra[6] = '{8'h00, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
  logic [32:0] rv[6] = '{33'h000000001, 33'h0, 33'h000000010, 33'h000000004, 33'h000000004, 33'h100000000};
  int          n_mismatch, compares;

  bfs_buck_fault_supervisor #(.PG_RISE_CYC(PG_N), .UV_DELAY_CYC(UV_N)) i_bfs_buck_fault_supervisor (.*);
  bfs_power_stage i_bfs_power_stage (.*);

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  // Expected {pslverr, prdata} is queued here and checked by the monitor at pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    exp_q.push_back(e);
    for (n = 0; pready !== 1'b1 && n < 20; n++) @(posedge pclk);
    if (n == 20) n_mismatch++;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  always @(posedge pclk) begin
    if (pready === 1'b1 && exp_q.size() > 0) check({pslverr, prdata}, exp_q.pop_front());
  end

  // Optional request, then the width of the next high-side pulse
  task automatic pulse(input logic req, input int exp_w);
    int n;
    int w;
    if (req) begin
      repeat (4 + $urandom % 4) @(posedge pclk);
      {zc_too_late, zc_too_early} <= 2'($urandom % 3);
      pwm_request <= 1'b1;
      @(posedge pclk);
      pwm_request <= 1'b0;
    end
    for (n = 0; high_side_on !== 1'b1 && n < 40; n++) @(posedge pclk);
    for (w = 0; high_side_on === 1'b1 && w < 300; w++) @(posedge pclk);
    check(33'(w), 33'(exp_w));
  endtask : pulse

  initial begin
    {psel, penable, pwrite, paddr, pwdata, soft_start_done, fb_in_window, fb_out_window, fb_below_uv} = '0;
    {fb_above_ov, fb_above_band, supply_below_off, supply_above_on, temp_over, pwm_request} = '0;
    {zc_too_late, zc_too_early, bias_reset, mode_tied_pg, force_trip, presetn} = '0;
    {temp_recovered, enable_pin} = 2'b11;
    void'($urandom(32'hE3C0CDC9));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, 8'h18, 32'h0000000F, 33'h0);
    for (int i = 0; i < 6; i++) apb(1'b0, ra[i], 32'h0, rv[i]);
    apb(1'b1, 8'h0C, 32'h00000002, 33'h0);
    supply_above_on <= 1'b1;
    fb_in_window    <= 1'b1;
    repeat (PG_N + 10) @(posedge pclk);
    check(33'(output_ok_flag), 33'h0);
    soft_start_done <= 1'b1;
    repeat (PG_N - 4) @(posedge pclk);
    check(33'(output_ok_flag), 33'h0);
    repeat (12) @(posedge pclk);
    check(33'(output_ok_flag), 33'h1);
    check(33'(irq), 33'h0);
    fb_in_window  <= 1'b0;
    fb_out_window <= 1'b1;
    repeat (45) @(posedge pclk);
    check(33'(output_ok_flag), 33'h1);
    repeat (15) @(posedge pclk);
    check(33'(output_ok_flag), 33'h0);
    check(33'(irq), 33'h1);
    fb_out_window <= 1'b0;
    apb(1'b1, 8'h08, 32'h00000002, 33'h0);
    check(33'(irq), 33'h0);
    apb(1'b1, 8'h0C, 32'h00000001, 33'h0);
    check(33'(irq), 33'h1);
    apb(1'b1, 8'h08, 32'h00000001, 33'h0);
    check(33'(irq), 33'h0);
    pulse(1'b1, 16);
    repeat (100) @(posedge pclk);
    check(33'(low_side_on), 33'h0);
    force_trip <= 1'b1;
    pulse(1'b1, 0);
    force_trip <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      {supply_below_off, supply_above_on} <= (k == 0) ? 2'b10 : 2'b01;
      {temp_over, temp_recovered}         <= (k == 1) ? 2'b10 : 2'b01;
      pulse(1'b1, 0);
      {supply_below_off, supply_above_on, temp_over, temp_recovered} <= 4'b0101;
      pulse(1'b1, 16);
    end
    fb_below_uv <= 1'b1;
    repeat (UV_N + 12) @(posedge pclk);
    check(33'({high_side_on, low_side_on}), 33'h0);
    fb_below_uv <= 1'b0;
    pulse(1'b1, 0);
    bias_reset <= 1'b1;
    repeat (2) @(posedge pclk);
    bias_reset <= 1'b0;
    pulse(1'b1, 16);
    repeat (100) @(posedge pclk);
    fb_above_ov <= 1'b1;
    repeat (8) @(posedge pclk);
    check(33'({high_side_on, low_side_on}), 33'h1);
    pulse(1'b0, 4);
    fb_above_ov <= 1'b0;
    fb_below_uv <= 1'b1;
    repeat (UV_N + 12) @(posedge pclk);
    fb_below_uv <= 1'b0;
    repeat (20) @(posedge pclk);
    check(33'({high_side_on, low_side_on}), 33'h1);
    enable_pin <= 1'b0;
    repeat (4) @(posedge pclk);
    enable_pin <= 1'b1;
    pulse(1'b1, 16);
    end_of_test();
  end

  initial begin
    repeat (4000) @(posedge pclk);
    n_mismatch++;
    end_of_test();
  end
endmodule : test_buck_fault_supervisor
